/* File: vopc_top.sv */
`default_nettype none
module vopc_top #(
    parameter int DEBOUNCE_CYCLES = vopc_pkg::DEBOUNCE_CYC,
    parameter int RAMP_STEPS      = vopc_pkg::RAMP_STEPS
) (
    input  wire logic                          SYS_CLK,
    input  wire logic                          RESETN,
    input  wire logic                          VOLUME_BUTTON_INPUT_N,
    input  wire logic [vopc_pkg::VOL_W-1:0]    NV_VOLUME_LEVEL,
    input  wire logic [vopc_pkg::CFG_W-1:0]    ANALOG_PATH_CONFIG,
    input  wire logic                          ANALOG_PATH_CONFIG_WE,
    input  wire logic                          POWER_DOWN,
    input  wire logic                          OPERATION_ACTIVE,
    input  wire logic                          SPEAKER_PWM_P,
    input  wire logic                          SPEAKER_PWM_N,
    output logic [vopc_pkg::VOL_W-1:0]         VOLUME_LEVEL,
    output logic                               VOLUME_DIR_UP,
    output logic                               SPEAKER_POS_OUT,
    output logic                               SPEAKER_POS_OE,
    output logic                               SPEAKER_NEG_OUT,
    output logic                               SPEAKER_NEG_OE,
    output logic                               AUX_VOLTAGE_MODE,
    output logic                               AUX_POWERED,
    output logic [$clog2(RAMP_STEPS+1)-1:0]    CURRENT_AUX_RAMP
);
    import vopc_pkg::*;
    localparam int RW = $clog2(RAMP_STEPS + 1);
    localparam int TW = $clog2(RAMP_STEP_CYC + 1);

    // Stepper, config, speaker and ramp state
    logic             btn_clean_n;
    logic             btn_fall;
    logic [VOL_W-1:0] vol_reg, vol_next;
    logic             dir_up_reg, dir_up_next;
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic             sp_p_reg, sp_n_reg, sp_oe_reg;
    logic             sp_p_next, sp_n_next, sp_oe_next;
    vopc_ramp_t       ramp_reg, ramp_next;
    logic [RW-1:0]    lvl_reg, lvl_next;
    logic [TW-1:0]    tick_reg, tick_next;
    logic             loaded_reg, loaded_next;
    logic             aux_pwr_reg, aux_pwr_next;

    // Pad pull-up idles the pin high; only filtering happens here
    vopc_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_deb (
        .sys_clk   (SYS_CLK),
        .resetn    (RESETN),
        .raw_n     (VOLUME_BUTTON_INPUT_N),
        .clean_n   (btn_clean_n),
        .fall_pulse(btn_fall)
    );

    // Volume stepper; a config write beats the button and the stored-level load
    always_comb begin
        vol_next    = vol_reg;
        dir_up_next = dir_up_reg;
        cfg_next    = cfg_reg;
        if (ANALOG_PATH_CONFIG_WE) begin
            cfg_next = ANALOG_PATH_CONFIG;
            vol_next = ANALOG_PATH_CONFIG[VOL_MSB:VOL_LSB];
            dir_up_next = (ANALOG_PATH_CONFIG[VOL_MSB:VOL_LSB] == VOL_MIN);
        end else if (!loaded_reg) begin
            vol_next    = NV_VOLUME_LEVEL;
            dir_up_next = (NV_VOLUME_LEVEL == VOL_MIN);
        end else if (btn_fall) begin
            if (dir_up_reg) begin
                vol_next = vol_reg + 1'b1;
                if (vol_next == VOL_MAX) begin
                    dir_up_next = 1'b0;
                end
            end else begin
                vol_next = vol_reg - 1'b1;
                if (vol_next == VOL_MIN) begin
                    dir_up_next = 1'b1;
                end
            end
        end
    end

    // Reset loads the default strap, the maximum; the stored level follows at the first edge after release
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            vol_reg    <= NV_VOL_DEFAULT;
            dir_up_reg <= 1'b0;
            cfg_reg    <= CFG_DEFAULT;
        end else begin
            vol_reg    <= vol_next;
            dir_up_reg <= dir_up_next;
            cfg_reg    <= cfg_next;
        end
    end

    // Output copy trails the stepper by one cycle, so the stored level
    // taken at the first edge after release shows at the second
    logic [VOL_W-1:0] vol_out_reg, vol_out_next;
    always_comb begin
        loaded_next  = 1'b1;
        vol_out_next = vol_reg;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            loaded_reg  <= 1'b0;
            vol_out_reg <= NV_VOL_DEFAULT;
        end else begin
            loaded_reg  <= loaded_next;
            vol_out_reg <= vol_out_next;
        end
    end

    // Aux power flag in its own flop, so the pin has no gate after it,
    // and it follows a config write on the same edge as the other flags
    always_comb begin
        aux_pwr_next = ~cfg_next[AUX_PD_BIT];
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            aux_pwr_reg <= ~CFG_DEFAULT[AUX_PD_BIT];
        end else begin
            aux_pwr_reg <= aux_pwr_next;
        end
    end

    // Speaker pair: drive only when powered and enabled, else float
    always_comb begin
        sp_oe_next = ~POWER_DOWN & cfg_reg[SPK_EN_BIT] & OPERATION_ACTIVE;
        sp_p_next  = sp_oe_next & SPEAKER_PWM_P;
        sp_n_next  = sp_oe_next & SPEAKER_PWM_N;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            sp_oe_reg <= 1'b0;
            sp_p_reg  <= 1'b0;
            sp_n_reg  <= 1'b0;
        end else begin
            sp_oe_reg <= sp_oe_next;
            sp_p_reg  <= sp_p_next;
            sp_n_reg  <= sp_n_next;
        end
    end

    // Anti-pop ramp; voltage mode or power-down skips it entirely
    always_comb begin
        ramp_next = ramp_reg;
        lvl_next  = lvl_reg;
        tick_next = tick_reg;
        if (cfg_reg[AUX_PD_BIT] || cfg_reg[AUX_TYPE_BIT] || POWER_DOWN) begin
            ramp_next = RAMP_IDLE;
            lvl_next  = '0;
            tick_next = '0;
        end else begin
            case (ramp_reg)
                RAMP_IDLE: begin
                    if (OPERATION_ACTIVE) begin
                        ramp_next = RAMP_UP;
                    end
                end
                RAMP_UP: begin
                    if (!OPERATION_ACTIVE) begin
                        ramp_next = RAMP_DOWN;
                    end else if (tick_reg == TW'(RAMP_STEP_CYC - 1)) begin
                        tick_next = '0;
                        lvl_next  = lvl_reg + 1'b1;
                        if (lvl_next == RW'(RAMP_STEPS)) begin
                            ramp_next = RAMP_HOLD;
                        end
                    end else begin
                        tick_next = tick_reg + 1'b1;
                    end
                end
                RAMP_HOLD: begin
                    if (!OPERATION_ACTIVE) begin
                        ramp_next = RAMP_DOWN;
                    end
                end
                RAMP_DOWN: begin
                    if (lvl_reg == '0) begin
                        ramp_next = RAMP_IDLE;
                        tick_next = '0;
                    end else if (tick_reg == TW'(RAMP_STEP_CYC - 1)) begin
                        tick_next = '0;
                        lvl_next  = lvl_reg - 1'b1;
                    end else begin
                        tick_next = tick_reg + 1'b1;
                    end
                end
                default: begin
                    ramp_next = RAMP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            ramp_reg <= RAMP_IDLE;
            lvl_reg  <= '0;
            tick_reg <= '0;
        end else begin
            ramp_reg <= ramp_next;
            lvl_reg  <= lvl_next;
            tick_reg <= tick_next;
        end
    end

    // Three-bit level covers exactly eight settings
    assign VOLUME_LEVEL     = vol_out_reg;
    assign VOLUME_DIR_UP    = dir_up_reg;
    assign SPEAKER_POS_OUT  = sp_p_reg;
    assign SPEAKER_NEG_OUT  = sp_n_reg;
    assign SPEAKER_POS_OE   = sp_oe_reg;
    assign SPEAKER_NEG_OE   = sp_oe_reg;
    assign AUX_VOLTAGE_MODE = cfg_reg[AUX_TYPE_BIT];
    assign AUX_POWERED      = aux_pwr_reg;
    assign CURRENT_AUX_RAMP = lvl_reg;
endmodule
`default_nettype wire

/* File: vopc_pkg.sv */
// Contract
// - Volume has exactly eight levels
// - Each debounced low pulse steps one level
// - Sweep down to minimum, then up to maximum
// - Load stored volume at power-up and reset
// - Shipped volume default is the highest level
// - Config bits two to zero also set volume
// - Button has pull-up, debounced press and release
// - Speaker pair tri-stated when down or unused
// - Config bit eight enables speaker, default on
// - Config bit seven selects aux current or voltage
// - Config bit nine powers down aux, default off
// - Current aux ramps up and down around operation
`default_nettype none
package vopc_pkg;
    localparam int VOL_W        = 3;
    localparam int CFG_W        = 10;
    localparam logic [2:0] VOL_MAX = 3'h7;
    localparam logic [2:0] VOL_MIN = 3'h0;
    localparam logic [2:0] NV_VOL_DEFAULT = 3'h7;
    localparam int VOL_LSB      = 0;
    localparam int VOL_MSB      = 2;
    localparam int AUX_TYPE_BIT = 7;
    localparam int SPK_EN_BIT   = 8;
    localparam int AUX_PD_BIT   = 9;
    // Speaker on, aux in current mode and powered, top volume
    localparam logic [9:0] CFG_DEFAULT = 10'h107;
    localparam int CLK_HZ       = 25_000_000;
    localparam int DEBOUNCE_US  = 20;
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int RAMP_STEPS   = 16;
    localparam int RAMP_STEP_US = 1;
    localparam int RAMP_STEP_CYC = (CLK_HZ / 1_000_000) * RAMP_STEP_US;
    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_UP   = 2'b01,
        RAMP_HOLD = 2'b10,
        RAMP_DOWN = 2'b11
    } vopc_ramp_t;
endpackage
`default_nettype wire

/* File: vopc_debounce.sv */
`default_nettype none
module vopc_debounce #(
    parameter int CYCLES = 500
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic raw_n,
    output logic      clean_n,
    output logic      fall_pulse
);
    localparam int CW = $clog2(CYCLES + 1);
    logic          clean_reg, clean_next;
    logic          fall_reg, fall_next;
    logic [CW-1:0] cnt_reg, cnt_next;

    // Accept a new level only after it stays put; both edges filtered
    always_comb begin
        clean_next = clean_reg;
        cnt_next   = '0;
        fall_next  = 1'b0;
        if (raw_n != clean_reg) begin
            if (cnt_reg == CW'(CYCLES - 1)) begin
                clean_next = raw_n;
                fall_next  = ~raw_n;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // Idle level is released (pulled up)
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            clean_reg <= 1'b1;
            cnt_reg   <= '0;
            fall_reg  <= 1'b0;
        end else begin
            clean_reg <= clean_next;
            cnt_reg   <= cnt_next;
            fall_reg  <= fall_next;
        end
    end

    assign clean_n    = clean_reg;
    assign fall_pulse = fall_reg;
endmodule
`default_nettype wire

/* File: vopc_props.sv */
`default_nettype none
module vopc_props
    import vopc_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = 4,
    parameter int RAMP_STEPS      = 16
) (
    input wire logic                          SYS_CLK,
    input wire logic                          RESETN,
    input wire logic [vopc_pkg::CFG_W-1:0]    ANALOG_PATH_CONFIG,
    input wire logic                          ANALOG_PATH_CONFIG_WE,
    input wire logic                          POWER_DOWN,
    input wire logic                          OPERATION_ACTIVE,
    input wire logic [vopc_pkg::VOL_W-1:0]    VOLUME_LEVEL,
    input wire logic                          VOLUME_DIR_UP,
    input wire logic                          SPEAKER_POS_OE,
    input wire logic                          SPEAKER_NEG_OE,
    input wire logic                          AUX_VOLTAGE_MODE,
    input wire logic                          AUX_POWERED,
    input wire logic [$clog2(RAMP_STEPS+1)-1:0] CURRENT_AUX_RAMP
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // Reset leaves top volume, downward sweep, speaker released
    rst_state_a: assert property (disable iff (1'b0) !RESETN |=> VOLUME_LEVEL == 3'h7
        && !VOLUME_DIR_UP && !SPEAKER_POS_OE && AUX_POWERED) else $error("bad reset state");
    pd_tristate_a: assert property (POWER_DOWN |=> !SPEAKER_POS_OE && !SPEAKER_NEG_OE)
        else $error("speaker driven in power down");
    idle_tristate_a: assert property (!OPERATION_ACTIVE |=> !SPEAKER_POS_OE && !SPEAKER_NEG_OE)
        else $error("speaker driven while unused");
    aux_mode_a: assert property (ANALOG_PATH_CONFIG_WE |=>
        AUX_VOLTAGE_MODE == $past(ANALOG_PATH_CONFIG[AUX_TYPE_BIT])) else $error("aux mode");
    aux_power_a: assert property (ANALOG_PATH_CONFIG_WE |=>
        AUX_POWERED != $past(ANALOG_PATH_CONFIG[AUX_PD_BIT])) else $error("aux power");
    cfg_volume_a: assert property (ANALOG_PATH_CONFIG_WE ##1 !ANALOG_PATH_CONFIG_WE |->
        ##1 VOLUME_LEVEL == $past(ANALOG_PATH_CONFIG[2:0], 2)) else $error("config volume");
    // Outside config writes and the reset preview, a level move is one step
    vol_step_a: assert property ($past(RESETN, 4) && !$past(ANALOG_PATH_CONFIG_WE)
        && !$past(ANALOG_PATH_CONFIG_WE, 2) && !$past(ANALOG_PATH_CONFIG_WE, 3)
        && $changed(VOLUME_LEVEL) |-> VOLUME_LEVEL == $past(VOLUME_LEVEL) + 3'h1
        || VOLUME_LEVEL == $past(VOLUME_LEVEL) - 3'h1) else $error("volume jump");
    dir_turn_a: assert property ($rose(VOLUME_DIR_UP) |-> ##[0:2] VOLUME_LEVEL == 3'h0)
        else $error("direction turned off minimum");
    ramp_off_a: assert property (AUX_VOLTAGE_MODE |-> ##[0:2] CURRENT_AUX_RAMP == '0)
        else $error("ramp in voltage mode");
    ramp_step_a: assert property (!POWER_DOWN && !$past(POWER_DOWN) && !AUX_VOLTAGE_MODE
        && !$past(AUX_VOLTAGE_MODE) && AUX_POWERED && $past(AUX_POWERED)
        && $changed(CURRENT_AUX_RAMP) |-> CURRENT_AUX_RAMP == $past(CURRENT_AUX_RAMP) + 1'b1
        || CURRENT_AUX_RAMP == $past(CURRENT_AUX_RAMP) - 1'b1) else $error("ramp jump");
endmodule
bind vopc_top vopc_props #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .RAMP_STEPS     (RAMP_STEPS)
) u_props (
    .SYS_CLK              (SYS_CLK),
    .RESETN               (RESETN),
    .ANALOG_PATH_CONFIG   (ANALOG_PATH_CONFIG),
    .ANALOG_PATH_CONFIG_WE(ANALOG_PATH_CONFIG_WE),
    .POWER_DOWN           (POWER_DOWN),
    .OPERATION_ACTIVE     (OPERATION_ACTIVE),
    .VOLUME_LEVEL         (VOLUME_LEVEL),
    .VOLUME_DIR_UP        (VOLUME_DIR_UP),
    .SPEAKER_POS_OE       (SPEAKER_POS_OE),
    .SPEAKER_NEG_OE       (SPEAKER_NEG_OE),
    .AUX_VOLTAGE_MODE     (AUX_VOLTAGE_MODE),
    .AUX_POWERED          (AUX_POWERED),
    .CURRENT_AUX_RAMP     (CURRENT_AUX_RAMP)
);
`default_nettype wire

/* File: vopc_switch_model.sv */
`default_nettype none
module vopc_switch_model (
    input  wire logic sys_clk,
    output logic      btn_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up keeps the line high when untouched
    initial btn_n = 1'b1;
    // Drive a contact level, then hold it for n clocks
    task automatic drv(input logic lvl, input int n);
        btn_n <= lvl;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Mechanical press: chatter on both make and break
    task automatic push(input int hold);
        drv(1'b0, 1);
        drv(1'b1, 1);
        drv(1'b0, hold);
        drv(1'b1, 1);
        drv(1'b0, 1);
        drv(1'b1, hold);
    endtask
endmodule
`default_nettype wire

/* File: vopc_tb_top.sv */
`default_nettype none
module vopc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB = 4;
    logic       clk, rst_n, btn_n, we, pd, act, dir, p_oe, n_oe, vmode, apwr, up;
    logic       sp, sn, pwm_p, pwm_n;
    logic [2:0] nv, lvl, e;
    logic [9:0] cfg;
    logic [4:0] ramp;
    int         fail_count, total_checks, i;
    vopc_switch_model u_sw (.sys_clk(clk), .btn_n(btn_n));
    vopc_top #(.DEBOUNCE_CYCLES(DEB), .RAMP_STEPS(16)) uut (.SYS_CLK(clk), .RESETN(rst_n),
        .VOLUME_BUTTON_INPUT_N(btn_n), .NV_VOLUME_LEVEL(nv), .ANALOG_PATH_CONFIG(cfg),
        .ANALOG_PATH_CONFIG_WE(we), .POWER_DOWN(pd), .OPERATION_ACTIVE(act),
        .SPEAKER_PWM_P(pwm_p), .SPEAKER_PWM_N(pwm_n), .VOLUME_LEVEL(lvl), .VOLUME_DIR_UP(dir),
        .SPEAKER_POS_OUT(sp), .SPEAKER_POS_OE(p_oe), .SPEAKER_NEG_OUT(sn), .SPEAKER_NEG_OE(n_oe),
        .AUX_VOLTAGE_MODE(vmode), .AUX_POWERED(apwr), .CURRENT_AUX_RAMP(ramp));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bounded wait on the level or the ramp; running out is a mismatch
    task automatic wait_on(input bit r, input logic [4:0] x);
        int n;
        for (n = 0; n < 600 && (r ? ramp : {2'b00, lvl}) !== x; n++) tick(1);
        chk(r ? ramp : {2'b00, lvl}, x);
        if (n == 600) conclude();
    endtask
    // Config word strobe; volume shows two edges later
    task automatic cfg_wr(input logic [9:0] v);
        cfg = v;
        we = 1'b1;
        tick(1);
        we = 1'b0;
        tick(2);
    endtask
    initial begin
        rst_n = 1'b0;
        {we, pd, act} = 3'b000;
        {pwm_p, pwm_n} = 2'b10;
        nv = 3'h5;
        cfg = 10'h000;
        tick(8);
        chk(lvl, 3'h7);
        rst_n = 1'b1;
        tick(2);
        chk(lvl, nv);
        tick(1);
        chk(lvl, nv);
        act = 1'b1;
        tick(2);
        chk(p_oe, 1'b1);
        chk({sp, sn}, 2'b10);
        chk({vmode, apwr}, 2'b01);
        wait_on(1'b1, 5'h10);
        act = 1'b0;
        wait_on(1'b1, 5'h00);
        // Chatter shorter than the filter must not step
        u_sw.drv(1'b0, DEB / 2);
        u_sw.drv(1'b1, 3 * DEB);
        chk(lvl, nv);
        e = nv;
        up = 1'b0;
        for (i = 0; i < 16; i++) begin
            up = (e == 3'h0) ? 1'b1 : (e == 3'h7) ? 1'b0 : up;
            e = up ? e + 3'h1 : e - 3'h1;
            u_sw.push(2 * DEB);
            wait_on(1'b0, {2'b00, e});
        end
        chk(dir, up);
        cfg_wr(10'h383);
        chk({vmode, apwr, lvl}, 5'b10011);
        act = 1'b1;
        cfg_wr(10'h003);
        chk(p_oe, 1'b0);
        {pwm_p, pwm_n} = 2'b01;
        cfg_wr(10'h100);
        chk({p_oe, n_oe, dir}, 3'b111);
        chk({sp, sn}, 2'b01);
        pd = 1'b1;
        tick(2);
        chk({p_oe, n_oe, sp, sn}, 4'b0000);
        conclude();
    end
endmodule
`default_nettype wire
